// ---- src/seq_defs.vh ----
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

// Clock and delay timebase
`define CLK_KHZ 25000
`define DELAY_UNIT_MS 1

// Link modes
`define LINK_NONE 2'h0
`define LINK_MANUAL 2'h1
`define LINK_AUTO 2'h2
`define LINK_CONT 2'h3

// Step types
`define TYPE_POS 2'h0
`define TYPE_PUSH 2'h1
`define TYPE_CONT 2'h2
`define TYPE_TORQUE 2'h3

// Successor codes (9-bit two's complement)
`define NEXT_STOP 9'h100
`define NEXT_PLUS2 9'h1fe
`define NEXT_PLUS1 9'h1ff

// Step entry layout
`define ENT_W 45
`define ENT_TYPE 44:43
`define ENT_LINK 42:41
`define ENT_NEXT 40:32
`define ENT_DELAY 31:16
`define ENT_SPEED 15:0
`define ENT_DEFAULT {`TYPE_POS, `LINK_NONE, `NEXT_PLUS1, 16'h0000, 16'h0000}

// Synchronised pin vector layout
`define PIN_W 21
`define PIN_START 0
`define PIN_LAUNCH 1
`define PIN_ADV 2
`define PIN_STOP 3
`define PIN_DSEL_EN 4
`define PIN_SEL 12:5
`define PIN_DIR 20:13

`define STEPS 256

`endif

// ---- src/motion_step_link_sequencer.v ----
// Overview of operation
// - Torque continuous steps run at stored speed with ramps bypassed until stopped.
// - Stop in torque mode halts at once; ready returns once motor rests.
// - Start while ready runs the step on the select lines or direct-select inputs and drops ready.
// - Ready returns when a single motion finishes and the motor rests.
// - Chain base step comes from select lines or direct-select inputs.
// - Positioning and push steps advance when command reaches target position.
// - Advance input moves any step type to its successor.
// - An event jump moves any step type to its successor.
// - Continuous steps never advance on position, only advance or event jump.
// - Link field: 0 none, 1 manual, 2 automatic, 3 continuous; default 0.
// - Successor: -256 stop, -2 plus two, -1 plus one (default), 0-255 direct.
// - A step with no link runs once and does not chain.
// - After a manual-link step, sequence-active stays high awaiting sequence launch.
// - Sequence launch while active starts the stored successor step.
// - Sequence launch while inactive starts the currently selected step.
// - A chain start drops ready, raises sequence-active, then moves the motor.
// - In manual mode ready rises after each step while sequence-active holds.
// - Chain end drops sequence-active and raises ready.
// - Automatic link waits the step's delay at rest, then starts the successor.
// - Reaching a no-link step ends the chain once its motion completes.
// - Continuous link starts the successor without stopping the motor.
`timescale 1ns/100ps
`include "seq_defs.vh"

module motion_step_link_sequencer
#(
  parameter MS_CYCLES = `CLK_KHZ * `DELAY_UNIT_MS
)
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Host command pins
  input wire start,
  input wire sequence_launch_input,
  input wire advance,
  input wire stop,
  input wire direct_select_en,
  input wire [7:0] step_select_lines,
  input wire [7:0] direct_step_inputs,
  // Host status pins
  output reg ready,
  output reg sequence_active_output,
  // Step table write port
  input wire table_wr_en,
  input wire [7:0] table_wr_addr,
  input wire [1:0] table_wr_type,
  input wire [1:0] table_wr_link,
  input wire [8:0] table_wr_next,
  input wire [15:0] table_wr_delay_ms,
  input wire [15:0] table_wr_speed,
  // Motion engine status
  input wire target_reached,
  input wire motor_at_rest,
  input wire event_jump,
  // Motion engine command
  output reg run_start,
  output reg [7:0] run_step,
  output reg [1:0] run_type,
  output reg [15:0] run_speed,
  output reg ramp_bypass,
  output reg stop_decel,
  output reg stop_immediate
);

  // ---------------------------------------------
  // States
  // ---------------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_RUN = 3'h1;
  localparam S_FINISH = 3'h2;
  localparam S_DELAY = 3'h3;
  localparam S_HALT = 3'h4;

  // After-finish actions
  localparam F_END = 2'h0;
  localparam F_MANUAL = 2'h1;
  localparam F_AUTO = 2'h2;

  // ---------------------------------------------
  // Functions
  // ---------------------------------------------
  // Returns {stop flag, next step}
  function [8:0] succ_step;
    input [7:0] cur;
    input [8:0] code;
    begin
      if (code == `NEXT_STOP)
        succ_step = {1'b1, cur};
      else if (code == `NEXT_PLUS2)
        succ_step = {1'b0, cur + 8'h02};
      else if (code == `NEXT_PLUS1)
        succ_step = {1'b0, cur + 8'h01};
      else if (code[8])
        succ_step = {1'b1, cur};
      else
        succ_step = {1'b0, code[7:0]};
    end
  endfunction

  function is_continuous;
    input [1:0] t;
    begin
      is_continuous = (t == `TYPE_CONT) || (t == `TYPE_TORQUE);
    end
  endfunction

  // ---------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------
  wire [`PIN_W-1:0] pins_raw;
  reg [`PIN_W-1:0] pins_meta_reg;
  reg [`PIN_W-1:0] pins_sync_reg;
  reg [`PIN_W-1:0] pins_last_reg;
  wire [`PIN_W-1:0] pins_rise;

  assign pins_raw = {direct_step_inputs, step_select_lines, direct_select_en,
    stop, advance, sequence_launch_input, start};

  genvar gi;
  generate
    for (gi = 0; gi < `PIN_W; gi = gi + 1)
    begin : g_sync
      always @(posedge clk)
      begin
        if (rst)
        begin
          pins_meta_reg[gi] <= 1'b0;
          pins_sync_reg[gi] <= 1'b0;
          pins_last_reg[gi] <= 1'b0;
        end
        else
        begin
          pins_meta_reg[gi] <= pins_raw[gi];
          pins_sync_reg[gi] <= pins_meta_reg[gi];
          pins_last_reg[gi] <= pins_sync_reg[gi];
        end
      end
      assign pins_rise[gi] = pins_sync_reg[gi] & ~pins_last_reg[gi];
    end
  endgenerate

  wire start_rise = pins_rise[`PIN_START];
  wire launch_rise = pins_rise[`PIN_LAUNCH];
  wire adv_rise = pins_rise[`PIN_ADV];
  wire stop_lvl = pins_sync_reg[`PIN_STOP];
  // Chain base step source
  wire [7:0] base_step = pins_sync_reg[`PIN_DSEL_EN] ?
    pins_sync_reg[`PIN_DIR] : pins_sync_reg[`PIN_SEL];

  // ---------------------------------------------
  // Step table
  // ---------------------------------------------
  reg [`ENT_W-1:0] table_mem [0:`STEPS-1];
  reg [`STEPS-1:0] table_valid_reg;

  always @(posedge clk)
  begin
    if (table_wr_en)
      table_mem[table_wr_addr] <= {table_wr_type, table_wr_link, table_wr_next,
        table_wr_delay_ms, table_wr_speed};
  end

  always @(posedge clk)
  begin
    if (rst)
      table_valid_reg <= {`STEPS{1'b0}};
    else if (table_wr_en)
      table_valid_reg[table_wr_addr] <= 1'b1;
  end

  // ---------------------------------------------
  // Sequencer
  // ---------------------------------------------
  reg [2:0] state_reg;
  reg [7:0] cur_reg;
  reg [`ENT_W-1:0] ent_reg;
  reg [7:0] pend_reg;
  reg [1:0] fin_reg;
  reg wait_man_reg;
  reg [15:0] delay_reg;
  reg [15:0] tick_cnt_reg;
  reg launch_go;
  reg [7:0] launch_step;
  reg [`ENT_W-1:0] launch_ent;
  reg [8:0] nxt;
  reg xfer;

  wire [1:0] cur_type = ent_reg[`ENT_TYPE];
  wire [1:0] cur_link = ent_reg[`ENT_LINK];
  wire ms_tick = ({16'h0000, tick_cnt_reg} == MS_CYCLES - 1);

  always @*
  begin
    nxt = succ_step(cur_reg, ent_reg[`ENT_NEXT]);
    xfer = (target_reached & ~is_continuous(cur_type))
      | adv_rise
      | event_jump;
    launch_go = 1'b0;
    launch_step = base_step;
    if (state_reg == S_IDLE)
    begin
      if (start_rise)
        launch_go = 1'b1;
      else if (launch_rise)
      begin
        launch_go = 1'b1;
        if (wait_man_reg)
          launch_step = pend_reg;
        else
          launch_step = base_step;
      end
    end
    else if (state_reg == S_RUN && xfer && !nxt[8] && cur_link == `LINK_CONT
      && !stop_lvl)
    begin
      launch_go = 1'b1;
      launch_step = nxt[7:0];
    end
    else if (state_reg == S_DELAY && delay_reg == 16'h0000)
    begin
      launch_go = 1'b1;
      launch_step = pend_reg;
    end
    if (table_valid_reg[launch_step])
      launch_ent = table_mem[launch_step];
    else
      launch_ent = `ENT_DEFAULT;
  end

  // Millisecond timebase
  always @(posedge clk)
  begin
    if (rst || state_reg != S_DELAY || ms_tick)
      tick_cnt_reg <= 16'h0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      cur_reg <= 8'h00;
      ent_reg <= `ENT_DEFAULT;
      pend_reg <= 8'h00;
      fin_reg <= F_END;
      wait_man_reg <= 1'b0;
      delay_reg <= 16'h0000;
      ready <= 1'b0;
      sequence_active_output <= 1'b0;
      run_start <= 1'b0;
      run_step <= 8'h00;
      run_type <= `TYPE_POS;
      run_speed <= 16'h0000;
      ramp_bypass <= 1'b0;
      stop_decel <= 1'b0;
      stop_immediate <= 1'b0;
    end
    else
    begin
      run_start <= 1'b0;
      stop_decel <= 1'b0;
      stop_immediate <= 1'b0;
      if (launch_go)
      begin
        cur_reg <= launch_step;
        ent_reg <= launch_ent;
        run_start <= 1'b1;
        run_step <= launch_step;
        run_type <= launch_ent[`ENT_TYPE];
        run_speed <= launch_ent[`ENT_SPEED];
        ramp_bypass <= (launch_ent[`ENT_TYPE] == `TYPE_TORQUE);
        ready <= 1'b0;
        wait_man_reg <= 1'b0;
        sequence_active_output <= (launch_ent[`ENT_LINK] != `LINK_NONE)
          || (state_reg != S_IDLE) || wait_man_reg;
        state_reg <= S_RUN;
      end
      else
      begin
        case (state_reg)
          S_IDLE:
            ready <= motor_at_rest;
          S_RUN:
          begin
            if (stop_lvl)
            begin
              if (cur_type == `TYPE_TORQUE)
              begin
                stop_immediate <= 1'b1;
                run_speed <= 16'h0000;
              end
              else
                stop_decel <= 1'b1;
              fin_reg <= F_END;
              state_reg <= S_HALT;
            end
            else if (xfer)
            begin
              pend_reg <= nxt[7:0];
              if (nxt[8] || cur_link == `LINK_NONE)
                fin_reg <= F_END;
              else if (cur_link == `LINK_MANUAL)
                fin_reg <= F_MANUAL;
              else
                fin_reg <= F_AUTO;
              delay_reg <= ent_reg[`ENT_DELAY];
              if (cur_type == `TYPE_TORQUE)
                stop_immediate <= 1'b1;
              else if (is_continuous(cur_type))
                stop_decel <= 1'b1;
              state_reg <= S_FINISH;
            end
          end
          S_HALT:
          begin
            if (motor_at_rest)
            begin
              ramp_bypass <= 1'b0;
              sequence_active_output <= 1'b0;
              ready <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          S_FINISH:
          begin
            if (motor_at_rest)
            begin
              ramp_bypass <= 1'b0;
              if (fin_reg == F_AUTO)
                state_reg <= S_DELAY;
              else
              begin
                ready <= 1'b1;
                wait_man_reg <= (fin_reg == F_MANUAL);
                sequence_active_output <= (fin_reg == F_MANUAL);
                state_reg <= S_IDLE;
              end
            end
          end
          S_DELAY:
          begin
            if (stop_lvl)
            begin
              sequence_active_output <= 1'b0;
              ready <= 1'b1;
              state_reg <= S_IDLE;
            end
            else if (ms_tick)
              delay_reg <= delay_reg - 16'h0001;
          end
          default:
            state_reg <= S_IDLE;
        endcase
      end
    end
  end

endmodule // motion_step_link_sequencer

// ---- bench/step_link_monitor.sv ----
`timescale 1ns/100ps
module step_link_monitor
#(
  parameter MS_CYCLES = 25000
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host pins
  input wire logic start,
  input wire logic stop,
  input wire logic ready,
  input wire logic sequence_active_output,
  // Motion engine side
  input wire logic motor_at_rest,
  input wire logic run_start,
  input wire logic [1:0] run_type,
  input wire logic ramp_bypass,
  input wire logic stop_decel,
  input wire logic stop_immediate
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_RDY_DROP: assert property (run_start |-> !ready)
    else $error("ready high at launch");
  AST_RUN_ONE: assert property (run_start |=> !run_start)
    else $error("launch pulse too long");
  AST_START_ANSWER: assert property ($rose(start) && ready && !stop |-> ##[3:4] run_start)
    else $error("start not answered");
  AST_TORQUE_BYPASS: assert property (run_start && run_type == 2'h3 |-> ramp_bypass)
    else $error("torque step ramped");
  AST_STOP_QUICK: assert property ($rose(stop) && ramp_bypass && !ready
    |-> ##[2:5] stop_immediate)
    else $error("torque stop not immediate");
  AST_TORQUE_NO_RAMP: assert property (stop_decel |-> !ramp_bypass)
    else $error("ramped stop on torque step");
  AST_IMM_PULSE: assert property (stop_immediate |=> !stop_immediate)
    else $error("instant stop pulse too long");
  AST_READY_REST: assert property ($rose(ready) |-> $past(motor_at_rest))
    else $error("ready while moving");
  AST_CHAIN_END: assert property ($fell(sequence_active_output) |-> ready)
    else $error("chain ended without ready");
  AST_WAIT_HOLD: assert property (ready && sequence_active_output |=> sequence_active_output)
    else $error("manual wait lost");

  cover property (ready && sequence_active_output);
  cover property (run_start && run_type == 2'h3);
  cover property (stop_immediate);
  cover property (stop_decel);
endmodule // step_link_monitor

bind motion_step_link_sequencer step_link_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
  .clk(clk), .rst(rst), .start(start), .stop(stop), .ready(ready),
  .sequence_active_output(sequence_active_output), .motor_at_rest(motor_at_rest),
  .run_start(run_start), .run_type(run_type), .ramp_bypass(ramp_bypass),
  .stop_decel(stop_decel), .stop_immediate(stop_immediate));

// ---- bench/motion_engine_model.sv ----
`timescale 1ns/100ps
module motion_engine_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands
  input wire logic run_start,
  input wire logic [1:0] run_type,
  input wire logic stop_decel,
  input wire logic stop_immediate,
  // Status
  output logic target_reached,
  output logic motor_at_rest
);
  logic [3:0] cnt_reg;
  logic mv_reg;

  always @(posedge clk)
  begin
    target_reached <= 1'b0;
    if (rst)
    begin
      cnt_reg <= 4'h0;
      mv_reg <= 1'b0;
      motor_at_rest <= 1'b1;
    end
    else if (run_start)
    begin
      cnt_reg <= 4'h6;
      mv_reg <= 1'b1;
      motor_at_rest <= 1'b0;
    end
    else if (stop_decel || stop_immediate)
    begin
      cnt_reg <= 4'h2;
      mv_reg <= 1'b0;
    end
    else if (cnt_reg == 4'h1)
    begin
      if (!mv_reg)
        motor_at_rest <= 1'b1;
      else
      begin
        // Continuous kinds get one stray target pulse and keep running
        target_reached <= 1'b1;
        mv_reg <= run_type[1];
        cnt_reg <= run_type[1] ? 4'h0 : 4'h3;
      end
    end
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end
endmodule // motion_engine_model

// ---- bench/motion_step_link_sequencer_bench.sv ----
`timescale 1ns/100ps
module motion_step_link_sequencer_bench;
  logic clk, rst, start, sequence_launch_input, advance, stop, direct_select_en;
  logic table_wr_en, event_jump, target_reached, motor_at_rest;
  logic [7:0] step_select_lines, direct_step_inputs, table_wr_addr, run_step;
  logic [1:0] table_wr_type, table_wr_link, run_type;
  logic [8:0] table_wr_next;
  logic [15:0] table_wr_delay_ms, table_wr_speed, run_speed;
  logic ready, sequence_active_output, run_start, ramp_bypass, stop_decel, stop_immediate;
  integer mismatches, checks_done, j;

  motion_step_link_sequencer #(.MS_CYCLES(4)) DUT (.clk(clk), .rst(rst), .start(start),
    .sequence_launch_input(sequence_launch_input), .advance(advance), .stop(stop),
    .direct_select_en(direct_select_en), .step_select_lines(step_select_lines),
    .direct_step_inputs(direct_step_inputs), .ready(ready),
    .sequence_active_output(sequence_active_output), .table_wr_en(table_wr_en),
    .table_wr_addr(table_wr_addr), .table_wr_type(table_wr_type),
    .table_wr_link(table_wr_link), .table_wr_next(table_wr_next),
    .table_wr_delay_ms(table_wr_delay_ms), .table_wr_speed(table_wr_speed),
    .target_reached(target_reached), .motor_at_rest(motor_at_rest), .event_jump(event_jump),
    .run_start(run_start), .run_step(run_step), .run_type(run_type), .run_speed(run_speed),
    .ramp_bypass(ramp_bypass), .stop_decel(stop_decel), .stop_immediate(stop_immediate));

  motion_engine_model engine (.clk(clk), .rst(rst), .run_start(run_start),
    .run_type(run_type), .stop_decel(stop_decel), .stop_immediate(stop_immediate),
    .target_reached(target_reached), .motor_at_rest(motor_at_rest));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task ckf(input logic g, input logic e);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: flag %b expected %b", $time, g, e);
      end
    end
  endtask

  task ckv(input logic [15:0] g, input logic [15:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  task wr(input logic [7:0] a, input logic [1:0] t, input logic [1:0] l,
    input logic [8:0] n, input logic [15:0] d, input logic [15:0] s);
    begin
      {table_wr_addr, table_wr_type, table_wr_link, table_wr_next} = {a, t, l, n};
      {table_wr_delay_ms, table_wr_speed} = {d, s};
      table_wr_en = 1'b1;
      @(posedge clk) #1;
    end
  endtask

  task wt(input logic v);
    integer i;
    begin
      i = 0;
      while (ready !== v && i < 400)
      begin
        @(posedge clk) #1;
        i = i + 1;
      end
      ckf(ready, v);
    end
  endtask

  // Raise start or launch, hold until ready drops
  task press(input logic l);
    begin
      if (l)
        sequence_launch_input = 1'b1;
      else
        start = 1'b1;
      wt(1'b0);
      sequence_launch_input = 1'b0;
      start = 1'b0;
    end
  endtask

  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  always #20 clk = ~clk;

  initial
  begin
    #(20000 * 40);
    mismatches = mismatches + 1;
    close_out;
  end

  initial
  begin
    rst = 1'b1;
    {clk, start, sequence_launch_input, advance, stop, direct_select_en} = 6'h00;
    {table_wr_en, event_jump, step_select_lines, direct_step_inputs} = 18'h00000;
    wr(8'h00, 2'h0, 2'h0, 9'h000, 16'h0000, 16'h0000);
    {mismatches, checks_done} = 64'h0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    wr(8'h00, 2'h0, 2'h1, 9'h1ff, 16'h0000, 16'h0100);
    wr(8'h01, 2'h1, 2'h2, 9'h005, 16'h0001, 16'h0200);
    wr(8'h05, 2'h0, 2'h0, 9'h100, 16'h0000, 16'h0300);
    wr(8'h02, 2'h3, 2'h0, 9'h100, 16'h0000, 16'h0aaa);
    wr(8'h03, 2'h2, 2'h3, 9'h1fe, 16'h0000, 16'h0400);
    table_wr_en = 1'b0;
    repeat (4) @(posedge clk);
    #1 press(1'b0);
    ckv({8'h00, run_step}, 16'h0000);
    ckf(sequence_active_output, 1'b1);
    wt(1'b1);
    ckf(sequence_active_output, 1'b1);
    press(1'b1);
    ckv({8'h00, run_step}, 16'h0001);
    wt(1'b1);
    ckv({8'h00, run_step}, 16'h0005);
    ckf(sequence_active_output, 1'b0);
    direct_select_en = 1'b1;
    direct_step_inputs = 8'h02;
    press(1'b0);
    ckv({8'h00, run_step}, 16'h0002);
    repeat (20) @(posedge clk);
    #1 ckf(ready, 1'b0);
    ckf(ramp_bypass, 1'b1);
    ckv(run_speed, 16'h0aaa);
    stop = 1'b1;
    wt(1'b1);
    stop = 1'b0;
    direct_select_en = 1'b0;
    for (j = 0; j < 2; j = j + 1)
    begin
      step_select_lines = 8'h03;
      press(1'b0);
      repeat (12) @(posedge clk);
      #1 ckv({8'h00, run_step}, 16'h0003);
      if (j == 0)
        advance = 1'b1;
      else
        event_jump = 1'b1;
      @(posedge clk) #1;
      event_jump = 1'b0;
      repeat (4) @(posedge clk);
      #1 advance = 1'b0;
      ckv({8'h00, run_step}, 16'h0005);
      wt(1'b1);
      ckf(sequence_active_output, 1'b0);
    end
    step_select_lines = 8'h04;
    press(1'b1);
    ckv({8'h00, run_step}, 16'h0004);
    wt(1'b1);
    ckf(sequence_active_output, 1'b0);
    ckv({8'h00, run_step}, 16'h0004);
    press(1'b0);
    stop = 1'b1;
    wt(1'b1);
    stop = 1'b0;
    ckf(ramp_bypass, 1'b0);
    ckf(sequence_active_output, 1'b0);
    close_out;
  end
endmodule // motion_step_link_sequencer_bench
